// ### pfg_regs.svh
// register offsets, field positions, reset values of the port f block
`ifndef PFG_REGS_SVH
`define PFG_REGS_SVH

// register byte offsets on the wishbone bus
`define PFG_OFS_DIR      5'h00
`define PFG_OFS_LATCH    5'h04
`define PFG_OFS_PINS     5'h08
`define PFG_OFS_CTRL     5'h0C
`define PFG_OFS_STATUS   5'h10

// control register field positions
`define PFG_CTRL_BUS16   0
`define PFG_CTRL_WAITEN  1
`define PFG_CTRL_BUS_RELEASE_ENABLE    2
`define PFG_CTRL_TRGLO   3
`define PFG_CTRL_TRGHI   4
`define PFG_CTRL_W       5

// status register field positions
`define PFG_STAT_EXP     0
`define PFG_STAT_MODE    1

// reset values
`define PFG_DIR_RST_EXP  8'h80
`define PFG_DIR_RST_SC   8'h00
`define PFG_LATCH_RST    8'h00
`define PFG_CTRL_RST     5'h00

// operating mode code of single-chip operation
`define PFG_MODE_SC      3'h7

// inactive level of the active-low bus inputs
`define PFG_IN_IDLE      1'b1

`endif

// ### pfg_pkg.sv
// types shared by the port f block
package pfg_pkg;

  // function that a pin takes on
  typedef enum logic [2:0] {
    PFG_FN_IN  = 3'h0,
    PFG_FN_OUT = 3'h1,
    PFG_FN_CLK = 3'h3,
    PFG_FN_BUS = 3'h2,
    PFG_FN_BIN = 3'h6
  } pfg_func_e;

  // all state of the top module
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [4:0] ctrl;
    logic [2:0] mode;
    logic       expanded;
    logic       ack;
    logic [7:0] dat;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic       wait_in;
    logic       bus_request_in_in;
    logic       trig_in;
    logic       ext_interrupt_two_in;
    logic       ext_interrupt_three_in;
  } pfg_state_s;

endpackage

// ### pfg_pin_mux.sv
// per-pin function decode of the port f pins
`timescale 1ns/100ps
module pfg_pin_mux
  import pfg_pkg::*;
(
  // configuration
  input  wire logic [7:0] dir_i,
  input  wire logic       expanded_i,
  input  wire logic       bus16_i,
  input  wire logic       wait_pin_enable_i,
  input  wire logic       bus_release_enable_i,
  // decoded functions
  output pfg_func_e       func_o [8]
);

  // plain port pin chosen by its direction bit
  function automatic pfg_func_e port_fn(input logic d);
    port_fn = d ? PFG_FN_OUT : PFG_FN_IN;
  endfunction

  // function of each pin from mode, bus settings and direction
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      func_o[i] = port_fn(dir_i[i]);
    end
    func_o[7] = dir_i[7] ? PFG_FN_CLK : PFG_FN_IN;
    if (expanded_i) begin
      func_o[6] = PFG_FN_BUS;
      func_o[5] = PFG_FN_BUS;
      func_o[4] = PFG_FN_BUS;
      if (bus16_i) begin
        func_o[3] = PFG_FN_BUS;
      end
      if (wait_pin_enable_i) begin
        func_o[2] = PFG_FN_BIN;
      end
      if (bus_release_enable_i) begin
        func_o[1] = PFG_FN_BUS;
        func_o[0] = PFG_FN_BIN;
      end
    end
  end

endmodule // pfg_pin_mux

// ### pfg_port.sv
// port f: eight shared pins with direction, latch and readback
`include "pfg_regs.svh"
`timescale 1ns/100ps
module pfg_port
  import pfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // operating mode strap
  input  wire logic [2:0]  mode_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // signals from clock and bus controller
  input  wire logic        sysclk_i,
  input  wire logic        address_strobe_out_i,
  input  wire logic        read_strobe_i,
  input  wire logic        high_byte_write_strobe_i,
  input  wire logic        low_byte_write_strobe_i,
  input  wire logic        bus_ack_i,
  // pin inputs handed to other blocks
  output logic             wait_in_o,
  output logic             bus_request_in_o,
  output logic             conversion_trigger_in_o,
  output logic             ext_interrupt_two_o,
  output logic             ext_interrupt_three_o,
  // pins
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o
);

  // registered state and its next value
  pfg_state_s st;
  pfg_state_s next_st;

  // decoded pin functions
  pfg_func_e  func [8];

  // bus request decode
  logic       req;
  logic       wr;
  logic       rd;
  logic       lane0;

  // control fields
  logic       bus16;
  logic       wait_pin_enable;
  logic       bus_release_enable;
  logic       trigger_select_low;
  logic       trigger_select_high;

  // per-pin drive terms
  logic [7:0] bus_drive;
  logic [7:0] fn_oe;
  logic [7:0] fn_out;
  logic [7:0] readback;

  // one cycle answer to every access
  assign req   = cyc_i & stb_i & ~st.ack;
  assign wr    = req & we_i;
  assign rd    = req & ~we_i;
  assign lane0 = sel_i[0];

  // control register fields
  assign bus16               = st.ctrl[`PFG_CTRL_BUS16];
  assign wait_pin_enable     = st.ctrl[`PFG_CTRL_WAITEN];
  assign bus_release_enable  = st.ctrl[`PFG_CTRL_BUS_RELEASE_ENABLE];
  assign trigger_select_low  = st.ctrl[`PFG_CTRL_TRGLO];
  assign trigger_select_high = st.ctrl[`PFG_CTRL_TRGHI];

  // pin function decode
  pfg_pin_mux u_mux (
    .dir_i                (st.dir),
    .expanded_i           (st.expanded),
    .bus16_i              (bus16),
    .wait_pin_enable_i    (wait_pin_enable),
    .bus_release_enable_i (bus_release_enable),
    .func_o               (func)
  );

  // bus controller strobes per pin position
  assign bus_drive = {1'b0,
                      address_strobe_out_i,
                      read_strobe_i,
                      high_byte_write_strobe_i,
                      low_byte_write_strobe_i,
                      1'b0,
                      bus_ack_i,
                      1'b0};

  // drive enable and level of each pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (func[i])
        PFG_FN_OUT: begin
          fn_oe[i]  = 1'b1;
          fn_out[i] = st.latch[i];
        end
        PFG_FN_CLK: begin
          fn_oe[i]  = 1'b1;
          fn_out[i] = sysclk_i;
        end
        PFG_FN_BUS: begin
          fn_oe[i]  = 1'b1;
          fn_out[i] = bus_drive[i];
        end
        PFG_FN_BIN: begin
          fn_oe[i]  = 1'b0;
          fn_out[i] = 1'b0;
        end
        default: begin
          fn_oe[i]  = 1'b0;
          fn_out[i] = 1'b0;
        end
      endcase
    end
  end

  // readback: latch for output bits, live pin for inputs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      readback[i] = st.dir[i] ? st.latch[i] : pin_i[i];
    end
  end

  // read data for a given offset
  function automatic logic [7:0] read_mux(input logic [4:0] a);
    case (a)
      `PFG_OFS_DIR:    read_mux = 8'h00;
      `PFG_OFS_LATCH:  read_mux = st.latch;
      `PFG_OFS_PINS:   read_mux = readback;
      `PFG_OFS_CTRL:   read_mux = {3'h0, st.ctrl};
      `PFG_OFS_STATUS: read_mux = {4'h0, st.mode, st.expanded};
      default:         read_mux = 8'h00;
    endcase
  endfunction

  // next state
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.dat = 8'h00;
    if (rd) begin
      next_st.dat = read_mux(adr_i);
    end
    if (wr && lane0) begin
      case (adr_i)
        `PFG_OFS_DIR: begin
          next_st.dir = dat_i[7:0];
        end
        `PFG_OFS_LATCH: begin
          next_st.latch = dat_i[7:0];
        end
        `PFG_OFS_CTRL: begin
          next_st.ctrl = dat_i[`PFG_CTRL_W-1:0];
        end
        default: begin
          next_st.dir = st.dir;
        end
      endcase
    end
    next_st.pin_oe  = fn_oe;
    next_st.pin_out = fn_out;
    // wait and request only pass while the pin is claimed, the trigger while both selects are set on an 8-bit bus
    next_st.wait_in = (func[2] == PFG_FN_BIN) ?
                      pin_i[2] : `PFG_IN_IDLE;
    next_st.bus_request_in_in = (func[0] == PFG_FN_BIN) ?
                      pin_i[0] : `PFG_IN_IDLE;
    next_st.trig_in = (st.expanded && !bus16 &&
                       trigger_select_low &&
                       trigger_select_high) ?
                      pin_i[3] : `PFG_IN_IDLE;
    // interrupt inputs always see the pin level
    next_st.ext_interrupt_two_in = pin_i[0];
    next_st.ext_interrupt_three_in = pin_i[3];
    if (rst_i) begin
      next_st.mode     = mode_i;
      next_st.expanded = (mode_i != `PFG_MODE_SC);
      next_st.dir      = (mode_i != `PFG_MODE_SC) ?
                         `PFG_DIR_RST_EXP :
                         `PFG_DIR_RST_SC;
      next_st.latch    = `PFG_LATCH_RST;
      next_st.ctrl     = `PFG_CTRL_RST;
      next_st.ack      = 1'b0;
      next_st.dat      = 8'h00;
      next_st.pin_oe   = 8'h00;
      next_st.pin_out  = 8'h00;
      next_st.wait_in  = `PFG_IN_IDLE;
      next_st.bus_request_in_in  = `PFG_IN_IDLE;
      next_st.trig_in  = `PFG_IN_IDLE;
      next_st.ext_interrupt_two_in  = pin_i[0];
      next_st.ext_interrupt_three_in  = pin_i[3];
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // outputs straight from the state register
  assign dat_o                   = {24'h000000, st.dat};
  assign ack_o                   = st.ack;
  assign pin_o                   = st.pin_out;
  assign pin_oe_o                = st.pin_oe;
  assign wait_in_o               = st.wait_in;
  assign bus_request_in_o        = st.bus_request_in_in;
  assign conversion_trigger_in_o = st.trig_in;
  assign ext_interrupt_two_o     = st.ext_interrupt_two_in;
  assign ext_interrupt_three_o   = st.ext_interrupt_three_in;

endmodule // pfg_port

// ### pfg_port_assertions.sv
// bound checker of the port f register bus and pin functions
`timescale 1ns/100ps
module pfg_port_assertions
  import pfg_pkg::*;
(
  // clock, reset, mode
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [2:0]  mode_i,
  // register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // function sources and pins
  input wire logic        sysclk_i,
  input wire logic        address_strobe_out_i,
  input wire logic        low_byte_write_strobe_i,
  input wire logic        bus_ack_i,
  input wire logic        wait_in_o,
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o
);
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] lat;
    logic [4:0] ctl;
  } pfg_shadow_s;
  pfg_shadow_s s, next_s;
  logic        x, tk, wr;
  logic [7:0]  rb;
  logic        live;
  // checks start one edge after reset release
  always_ff @(posedge clk_i) live <= !rst_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !live);
  // request decode and expected readback
  assign x  = mode_i != 3'h7;
  assign tk = cyc_i && stb_i && !ack_o;
  assign wr = tk && we_i && sel_i[0];
  assign rb = (s.dir & s.lat) | (~s.dir & pin_i);
  // shadow copy of the registers
  always_comb begin
    next_s = s;
    if (wr && adr_i == 5'h00) next_s.dir = dat_i[7:0];
    if (wr && adr_i == 5'h04) next_s.lat = dat_i[7:0];
    if (wr && adr_i == 5'h0C) next_s.ctl = dat_i[4:0];
    if (rst_i) next_s = '0;
    if (rst_i) next_s.dir = x ? 8'h80 : 8'h00;
  end
  always_ff @(posedge clk_i) s <= next_s;
  sequence s_rd(logic [4:0] a); tk && !we_i && adr_i == a; endsequence
  sequence s_pulse; ack_o ##1 !ack_o; endsequence
  property p_ack; tk |=> s_pulse; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_lat; s_rd(5'h04) |=> dat_o == {24'h0, $past(s.lat)}; endproperty
  a_lat: assert property (p_lat) else $error("latch read");
  property p_rb; s_rd(5'h08) |=> dat_o[7:0] == $past(rb); endproperty
  a_rb: assert property (p_rb) else $error("readback value");
  property p_bus;
    x |=> pin_oe_o[6:4] == 3'h7 && pin_o[6] == $past(address_strobe_out_i);
  endproperty
  a_bus: assert property (p_bus) else $error("strobe pins");
  property p_clk; s.dir[7] |=> pin_oe_o[7] && pin_o[7] == $past(sysclk_i);
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin");
  property p_sc; !x |=> pin_oe_o == $past(s.dir)
    && ((pin_o ^ $past(s.lat)) & pin_oe_o & 8'h7F) == 8'h00; endproperty
  a_sc: assert property (p_sc) else $error("single-chip pins");
  property p_rel; x && s.ctl[2] |=> pin_oe_o[1:0] == 2'b10
    && pin_o[1] == $past(bus_ack_i); endproperty
  a_rel: assert property (p_rel) else $error("bus release pins");
  property p_wait;
    x && s.ctl[1] |=> !pin_oe_o[2] && wait_in_o == $past(pin_i[2]);
  endproperty
  a_wait: assert property (p_wait) else $error("wait pin");
  property p_lwr; x && s.ctl[0] |=> pin_oe_o[3]
    && pin_o[3] == $past(low_byte_write_strobe_i); endproperty
  a_lwr: assert property (p_lwr) else $error("low strobe pin");
endmodule // pfg_port_assertions

bind pfg_port pfg_port_assertions i_pfg_port_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sysclk_i(sysclk_i),
  .address_strobe_out_i(address_strobe_out_i),
  .low_byte_write_strobe_i(low_byte_write_strobe_i),
  .bus_ack_i(bus_ack_i), .wait_in_o(wait_in_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o));

// ### pfg_pins_model.sv
// far-side pin model: external parts meeting the port pins
`timescale 1ns/100ps
module pfg_pins_model (
  // port side
  input  wire logic [7:0] po_i,
  input  wire logic [7:0] oe_i,
  // external drive, new value every cycle
  input  wire logic [7:0] ext_i,
  // resolved pin level
  output logic      [7:0] lvl_o
);
  // outside parts let go wherever the port drives
  assign lvl_o = (oe_i & po_i) | (~oe_i & ext_i);
endmodule // pfg_pins_model

// ### tb_pfg_port.sv
// self-checking bench of the port f block
`timescale 1ns/100ps
module tb_pfg_port import pfg_pkg::*;;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [2:0]  mode_i = 3'h4;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [5:0]  src = 6'h00, src_d = 6'h00;
  logic        wait_in_o, bus_request_in_o, conversion_trigger_in_o;
  logic        ext_interrupt_two_o, ext_interrupt_three_o;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [7:0]  ext = 8'h00, pin_i, pin_o, pin_oe_o, pv, rd, pin_d;
  integer      seed = 32'hc460;
  int          mismatches = 0, n_tests = 0, dir, lat, ctl;
  // 40 MHz clock and random far-side levels
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ext <= 8'($random(seed));
    src <= 6'($random(seed));
    src_d <= src;
    pin_d <= pin_i;
  end
  pfg_port i_pfg_port (
    .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sysclk_i(src[0]),
    .address_strobe_out_i(src[1]), .read_strobe_i(src[2]),
    .high_byte_write_strobe_i(src[3]), .low_byte_write_strobe_i(src[4]),
    .bus_ack_i(src[5]), .wait_in_o(wait_in_o),
    .bus_request_in_o(bus_request_in_o),
    .conversion_trigger_in_o(conversion_trigger_in_o),
    .ext_interrupt_two_o(ext_interrupt_two_o),
    .ext_interrupt_three_o(ext_interrupt_three_o),
    .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o));
  pfg_pins_model i_pfg_pins_model (.po_i(pin_o), .oe_i(pin_oe_o),
    .ext_i(ext), .lvl_o(pin_i));
  // compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // classic single wishbone cycle, updates the bench model
  task automatic wb(input logic w, input logic [4:0] a, input int d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    pv = pin_i;
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (w && a == 5'h00) dir = d;
    if (w && a == 5'h04) lat = d;
    if (w && a == 5'h0C) ctl = d;
  endtask
  // expected pin drive from the bench model
  task automatic pins(input logic x);
    logic [7:0] e, v, g;
    logic [4:0] t;
    e = 8'(dir);
    v = 8'(lat);
    if (dir[7]) v[7] = src_d[0];
    if (x) begin
      e[6:4] = 3'h7;
      v[6:4] = {src_d[1], src_d[2], src_d[3]};
      if (ctl[0]) e[3] = 1'b1;
      if (ctl[0]) v[3] = src_d[4];
      if (ctl[1]) e[2] = 1'b0;
      if (ctl[2]) e[1:0] = 2'b10;
      if (ctl[2]) v[1] = src_d[5];
    end
    // taps: wait, request, trigger, interrupt two, interrupt three
    t = 5'h1F;
    if (x && ctl[1]) t[4] = pin_d[2];
    if (x && ctl[2]) t[3] = pin_d[0];
    if (x && !ctl[0] && ctl[3] && ctl[4]) t[2] = pin_d[3];
    t[1] = pin_d[0];
    t[0] = pin_d[3];
    g = {3'h0, wait_in_o, bus_request_in_o, conversion_trigger_in_o,
         ext_interrupt_two_o, ext_interrupt_three_o};
    chk(pin_oe_o, e);
    chk(pin_o & e, v & e);
    chk(g, {3'h0, t});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog: the tests need about 290 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
  // expanded mode, then single-chip mode
  initial begin
    for (int k = 0; k < 2; k++) begin
      rst_i <= 1'b1;
      mode_i <= k ? 3'h7 : 3'h4;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      dir = k ? 0 : 8'h80;
      lat = 0;
      ctl = 0;
      @(posedge clk_i);
      wb(1'b0, 5'h08, 0);
      chk(rd, (8'(dir) & 8'(lat)) | (~8'(dir) & pv));
      pins(!k);
      wb(1'b0, 5'h00, 0);
      chk(rd, 8'h00);
      wb(1'b1, 5'h08, 8'hFF);
      repeat (8) begin
        wb(1'b1, 5'h00, $random(seed) & 8'hFF);
        wb(1'b1, 5'h04, $random(seed) & 8'hFF);
        wb(1'b1, 5'h0C, $random(seed) & 5'h1F);
        pins(!k);
        wb(1'b0, 5'h04, 0);
        chk(rd, 8'(lat));
        wb(1'b0, 5'h08, 0);
        chk(rd, (8'(dir) & 8'(lat)) | (~8'(dir) & pv));
      end
      // 8-bit bus with wait, release and both trigger selects
      wb(1'b1, 5'h0C, 5'h1E);
      pins(!k);
      $display("test mode %0d done", mode_i);
    end
    conclude();
  end
endmodule // tb_pfg_port
